/* rtl/smsa_pkg.sv */
// Purpose: constants and types for the safe motion status word assembler
// Assumes: source words come from logic on the same clock
// Notes: 2-byte status layout with binary mode code and functional inputs
package smsa_pkg;

   // ==========================================================
   // source word bit positions
   localparam int ST_ESTOP = 1;
   localparam int ST_STANDSTILL = 2;
   localparam int ST_MODE_LO = 3;
   localparam int MODE_N = 8;
   localparam int ST_FAULT = 25;
   localparam int ST_PARK = 27;
   localparam int POS_REF = 5;
   localparam int POS_ENC = 6;
   localparam int FN_A = 0;
   localparam int FN_B = 1;
   localparam int FN_C = 2;
   localparam int FN_D = 3;

   // ==========================================================
   // register map
   localparam int AW = 8;
   localparam logic [7:0] ADR_CFG = 8'h00;
   localparam logic [7:0] ADR_STAT = 8'h04;
   localparam logic [7:0] ADR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADR_IRQ_CLR = 8'h0C;
   localparam logic [7:0] ADR_IRQ_EN = 8'h10;
   localparam int CFG_W = 10;
   localparam int CFG_CON_LSB = 0;
   localparam int CFG_PRO_LSB = 16;
   localparam int CFG_BUS_LSB = 28;
   localparam int STAT_OK_BIT = 16;
   localparam int STAT_CONF_BIT = 17;
   localparam int STAT_NONE_BIT = 18;
   localparam int IRQ_CHG = 0;
   localparam int IRQ_PROF = 1;
   localparam int IRQ_MODE = 2;
   localparam int IRQ_N = 3;
   localparam logic [IRQ_N-1:0] IRQ_RST = 3'h0;

   // ==========================================================
   // predefined configuration numbers
   localparam logic [9:0] CON_778 = 10'h30A;
   localparam logic [9:0] CON_779 = 10'h30B;
   localparam logic [9:0] CON_780 = 10'h30C;
   localparam logic [9:0] CON_781 = 10'h30D;
   localparam logic [9:0] CON_786 = 10'h312;
   localparam logic [9:0] CON_787 = 10'h313;
   localparam logic [9:0] PRO_782 = 10'h30E;
   localparam logic [9:0] PRO_783 = 10'h30F;
   localparam logic [9:0] PRO_784 = 10'h310;
   localparam logic [9:0] PRO_785 = 10'h311;
   localparam logic [9:0] PRO_788 = 10'h314;
   localparam logic [9:0] PRO_789 = 10'h315;
   localparam logic [9:0] PRO_790 = 10'h316;

   typedef enum logic [1:0] {
      BUS_CSOS = 2'b00,
      BUS_FSOE = 2'b01,
      BUS_PNET = 2'b10
   } smsa_bus_t;

   localparam logic [31:0] CFG_MASK = 32'h30000000 | 32'h03FF03FF;
   localparam logic [31:0] CFG_RST = {2'h0, BUS_CSOS, 2'h0, PRO_790, 6'h00, CON_787};

   // ==========================================================
   // carriers
   typedef struct packed {
      logic overall_safe_flag;
      logic encoder_stopped_flag;
      logic safety_fault_flag;
      logic brake_ack_flag;
      logic rsvd;
      logic axis_parked_flag;
      logic func_in_d;
      logic func_in_c;
      logic func_in_b;
      logic func_in_a;
      logic safe_reference_flag;
      logic motion_mode_code_b2;
      logic motion_mode_code_b1;
      logic motion_mode_code_b0;
      logic safe_standstill_flag;
      logic estop_mode_flag;
   } smsa_word_t;

   typedef struct packed {
      logic [31:0] state;
      logic [15:0] pos;
      logic [15:0] func;
      logic brake;
      logic safe;
   } smsa_src_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [AW-1:0] addr;
      logic [31:0] wdata;
   } smsa_req_t;

endpackage

/* rtl/smsa_profile_chk.sv */
// Purpose: decide whether a consumer/producer pairing is allowed on a bus
// Assumes: configuration numbers held as 10-bit values
// Notes: combinational, no state
module smsa_profile_chk
   import smsa_pkg::*;
(
   // selection
   input wire smsa_bus_t bus,
   input wire logic [CFG_W-1:0] con,
   input wire logic [CFG_W-1:0] pro,
   // verdict
   output logic legal
);

   logic con_pre;
   logic pro_pre;
   logic pair_2b;

   always_comb
   begin
      con_pre = (con == CON_778) || (con == CON_779) || (con == CON_780)
         || (con == CON_781) || (con == CON_786) || (con == CON_787);
      pro_pre = (pro == PRO_782) || (pro == PRO_783) || (pro == PRO_784)
         || (pro == PRO_785) || (pro == PRO_788) || (pro == PRO_789)
         || (pro == PRO_790);
      // 2-byte pairs, allowed on every bus
      pair_2b = ((con == CON_780) && (pro == PRO_784))
         || ((con == CON_781) && (pro == PRO_785))
         || ((con == CON_787) && (pro == PRO_788))
         || ((con == CON_787) && (pro == PRO_790))
         || ((con == CON_786) && (pro == PRO_789))
         || ((con == CON_786) && (pro == PRO_784));
      legal = 1'b0;
      unique case (bus)
         // any predefined pairing; 1-byte ones only here
         BUS_CSOS: legal = con_pre && pro_pre;
         BUS_FSOE: legal = pair_2b;
         BUS_PNET: legal = pair_2b;
         default: legal = 1'b0;
      endcase
   end

endmodule

/* rtl/smsa_assembler.sv */
// Purpose: assemble the 2-byte safety status word sent to the controller
// Assumes: source words on CLK; register port with read data a cycle later
// Notes: CE low freezes all state except the reset release stages, and drops bus accesses
//
// Added by the designer: the register offsets and the address-and-strobe port.
module smsa_assembler
   import smsa_pkg::*;
(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // source status words
   input wire smsa_src_t SRC,
   // register port
   input wire smsa_req_t BUS_REQ,
   output logic [31:0] BUS_RDATA,
   // status word to the safety bus
   output smsa_word_t TX_WORD,
   output logic TX_PROFILE_OK,
   // interrupt
   output logic IRQ
);

   // ==========================================================
   // reset release
   logic rst_s1_r;
   logic rst_n;

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rst_s1_r <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_n <= rst_s1_r;
      end
   end

   // ==========================================================
   // mode encoding
   logic [MODE_N-1:0] mode_vec;
   logic [2:0] mode_code;
   logic mode_conflict;
   logic mode_none;

   assign mode_vec = SRC.state[ST_MODE_LO +: MODE_N];

   // lowest active mode wins; code is mode number minus one
   always_comb
   begin
      mode_code = 3'h0;
      mode_conflict = 1'b0;
      mode_none = 1'b1;
      for (int i = MODE_N - 1; i >= 0; i--)
      begin
         if (mode_vec[i])
         begin
            mode_code = i[2:0];
         end
      end
      if (mode_vec != '0)
      begin
         mode_none = 1'b0;
      end
      if ((mode_vec & (mode_vec - MODE_N'(1))) != '0)
      begin
         mode_conflict = 1'b1;
      end
   end

   // ==========================================================
   // word assembly
   smsa_word_t word_nxt;
   smsa_word_t word_r;

   always_comb
   begin
      word_nxt = '0;
      word_nxt.estop_mode_flag = SRC.state[ST_ESTOP];
      word_nxt.safe_standstill_flag = SRC.state[ST_STANDSTILL];
      word_nxt.motion_mode_code_b0 = mode_code[0];
      word_nxt.motion_mode_code_b1 = mode_code[1];
      word_nxt.motion_mode_code_b2 = mode_code[2];
      word_nxt.safe_reference_flag = SRC.pos[POS_REF];
      word_nxt.func_in_a = SRC.func[FN_A];
      word_nxt.func_in_b = SRC.func[FN_B];
      word_nxt.func_in_c = SRC.func[FN_C];
      word_nxt.func_in_d = SRC.func[FN_D];
      word_nxt.axis_parked_flag = SRC.state[ST_PARK];
      word_nxt.rsvd = 1'b0;
      word_nxt.brake_ack_flag = SRC.brake;
      word_nxt.safety_fault_flag = SRC.state[ST_FAULT];
      word_nxt.encoder_stopped_flag = SRC.pos[POS_ENC];
      word_nxt.overall_safe_flag = SRC.safe;
   end

   logic conflict_r;
   logic none_r;

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         word_r <= '0;
         conflict_r <= 1'b0;
         none_r <= 1'b1;
      end
      else if (CE)
      begin
         word_r <= word_nxt;
         conflict_r <= mode_conflict;
         none_r <= mode_none;
      end
   end

   assign TX_WORD = word_r;

   // ==========================================================
   // configuration and profile check
   logic [31:0] cfg_r;
   logic wr_cfg;
   logic legal;
   logic prof_ok_r;

   assign wr_cfg = CE && BUS_REQ.wr && (BUS_REQ.addr == ADR_CFG);

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_r <= CFG_RST;
      end
      else if (wr_cfg)
      begin
         cfg_r <= BUS_REQ.wdata & CFG_MASK;
      end
   end

   smsa_profile_chk u_chk (
      .bus(smsa_bus_t'(cfg_r[CFG_BUS_LSB +: 2])),
      .con(cfg_r[CFG_CON_LSB +: CFG_W]),
      .pro(cfg_r[CFG_PRO_LSB +: CFG_W]),
      .legal(legal)
   );

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prof_ok_r <= 1'b0;
      end
      else if (CE)
      begin
         prof_ok_r <= legal;
      end
   end

   assign TX_PROFILE_OK = prof_ok_r;

   // ==========================================================
   // interrupts
   logic [IRQ_N-1:0] ev;
   logic [IRQ_N-1:0] irq_stat_r;
   logic [IRQ_N-1:0] irq_en_r;
   logic [IRQ_N-1:0] clr;

   always_comb
   begin
      ev = '0;
      ev[IRQ_CHG] = CE && (word_nxt != word_r);
      ev[IRQ_PROF] = CE && prof_ok_r && !legal;
      ev[IRQ_MODE] = CE && mode_conflict && !conflict_r;
      clr = '0;
      if (CE && BUS_REQ.wr && (BUS_REQ.addr == ADR_IRQ_CLR))
      begin
         clr = BUS_REQ.wdata[IRQ_N-1:0];
      end
   end

   // a new event beats a clear in the same cycle
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_stat_r <= IRQ_RST;
      end
      else if (CE)
      begin
         irq_stat_r <= (irq_stat_r & ~clr) | ev;
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         irq_en_r <= IRQ_RST;
      end
      else if (CE && BUS_REQ.wr && (BUS_REQ.addr == ADR_IRQ_EN))
      begin
         irq_en_r <= BUS_REQ.wdata[IRQ_N-1:0];
      end
   end

   assign IRQ = |(irq_stat_r & irq_en_r);

   // ==========================================================
   // read path
   logic [31:0] stat_rd;
   logic [31:0] rdata_nxt;
   logic [31:0] rdata_r;

   always_comb
   begin
      stat_rd = '0;
      stat_rd[$bits(smsa_word_t)-1:0] = word_r;
      stat_rd[STAT_OK_BIT] = prof_ok_r;
      stat_rd[STAT_CONF_BIT] = conflict_r;
      stat_rd[STAT_NONE_BIT] = none_r;
      rdata_nxt = '0;
      if (CE && BUS_REQ.rd)
      begin
         case (BUS_REQ.addr)
            ADR_CFG: rdata_nxt = cfg_r;
            ADR_STAT: rdata_nxt = stat_rd;
            ADR_IRQ_STAT: rdata_nxt[IRQ_N-1:0] = irq_stat_r;
            ADR_IRQ_EN: rdata_nxt[IRQ_N-1:0] = irq_en_r;
            default: rdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r <= '0;
      end
      else if (CE)
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign BUS_RDATA = rdata_r;

   // ==========================================================
   // checks
   property p_estop;
      @(posedge CLK) disable iff (!rst_n)
      $past(CE) |-> word_r.estop_mode_flag == $past(SRC.state[ST_ESTOP]);
   endproperty
   a_estop: assert property (p_estop)
      else $error("estop flag not copied");

   property p_standstill;
      @(posedge CLK) disable iff (!rst_n)
      $past(CE) |-> word_r.safe_standstill_flag == $past(SRC.state[ST_STANDSTILL]);
   endproperty
   a_standstill: assert property (p_standstill)
      else $error("standstill flag not copied");

   property p_mode5;
      @(posedge CLK) disable iff (!rst_n)
      CE && (mode_vec == 8'h10) |=> {word_r.motion_mode_code_b2,
         word_r.motion_mode_code_b1, word_r.motion_mode_code_b0} == 3'h4;
   endproperty
   a_mode5: assert property (p_mode5)
      else $error("mode five misencoded");

   property p_ref_func;
      @(posedge CLK) disable iff (!rst_n)
      $past(CE) |-> (word_r.safe_reference_flag == $past(SRC.pos[POS_REF]))
         && ({word_r.func_in_b, word_r.func_in_a} == $past(SRC.func[FN_B:FN_A]));
   endproperty
   a_ref_func: assert property (p_ref_func)
      else $error("reference or inputs one two wrong");

   property p_byte1_low;
      @(posedge CLK) disable iff (!rst_n)
      $past(CE) |-> ({word_r.axis_parked_flag, word_r.func_in_d, word_r.func_in_c}
         == {$past(SRC.state[ST_PARK]), $past(SRC.func[FN_D:FN_C])});
   endproperty
   a_byte1_low: assert property (p_byte1_low)
      else $error("byte one low bits wrong");

   property p_byte1_high;
      @(posedge CLK) disable iff (!rst_n)
      $past(CE) |-> TX_WORD[15:12] == {$past(SRC.safe), $past(SRC.pos[POS_ENC]),
         $past(SRC.state[ST_FAULT]), $past(SRC.brake)};
   endproperty
   a_byte1_high: assert property (p_byte1_high)
      else $error("byte one high bits wrong");

   property p_rsvd;
      @(posedge CLK) disable iff (!rst_n)
      TX_WORD.rsvd == 1'b0;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved bit set");

   property p_fsoe_1byte;
      @(posedge CLK) disable iff (!rst_n)
      CE && (cfg_r == {2'h0, BUS_FSOE, 2'h0, PRO_782, 6'h00, CON_778})
         |=> !TX_PROFILE_OK;
   endproperty
   a_fsoe_1byte: assert property (p_fsoe_1byte)
      else $error("1-byte profile accepted off sercos");

   property p_csos_any;
      @(posedge CLK) disable iff (!rst_n)
      CE && (cfg_r == {2'h0, BUS_CSOS, 2'h0, PRO_790, 6'h00, CON_778})
         |=> TX_PROFILE_OK;
   endproperty
   a_csos_any: assert property (p_csos_any)
      else $error("free pairing refused on sercos");

   property p_pnet_pair;
      @(posedge CLK) disable iff (!rst_n)
      CE && (cfg_r == {2'h0, BUS_PNET, 2'h0, PRO_789, 6'h00, CON_786})
         |=> TX_PROFILE_OK;
   endproperty
   a_pnet_pair: assert property (p_pnet_pair)
      else $error("defined pair refused");

   property p_set_wins;
      @(posedge CLK) disable iff (!rst_n)
      ev[IRQ_CHG] && clr[IRQ_CHG] |=> irq_stat_r[IRQ_CHG];
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("event lost against clear");

   property p_rd_stat;
      @(posedge CLK) disable iff (!rst_n)
      CE && BUS_REQ.rd && (BUS_REQ.addr == ADR_STAT)
         |=> ((BUS_RDATA[$bits(smsa_word_t)-1:0] == $past(word_r))
         && (BUS_RDATA[STAT_OK_BIT] == $past(TX_PROFILE_OK)))
         ##1 ($past(BUS_REQ.rd) || !$past(CE) || (BUS_RDATA == '0));
   endproperty
   a_rd_stat: assert property (p_rd_stat)
      else $error("status read data wrong");

endmodule

/* dv/smsa_ctrl_model.sv */
// Purpose: far-end safety controller that receives the status word
// Assumes: only predefined configuration numbers are ever presented
// Notes: judges which consumer/producer pairing the controller accepts
module smsa_ctrl_model
   import smsa_pkg::*;
(
   // configuration under test
   input wire logic [1:0] bus,
   input wire logic [CFG_W-1:0] con,
   input wire logic [CFG_W-1:0] pro,
   // data received from the drive
   input wire smsa_word_t rx_word,
   // what the controller sees
   output logic pair_ok,
   output logic [7:0] rx_b0,
   output logic [7:0] rx_b1
);
   timeunit 1ns;
   timeprecision 1ns;
   logic defined_pair;

   // ==========================================================
   // profile table
   always_comb
   begin
      defined_pair = (con == CON_780 && pro == PRO_784) ||
         (con == CON_781 && pro == PRO_785) ||
         (con == CON_787 && (pro == PRO_788 || pro == PRO_790)) ||
         (con == CON_786 && (pro == PRO_789 || pro == PRO_784));
   end

   always_comb
   begin
      case (bus)
         2'h0: pair_ok = 1'b1;
         2'h1, 2'h2: pair_ok = defined_pair;
         default: pair_ok = 1'b0;
      endcase
   end

   // ==========================================================
   // received bytes
   assign rx_b0 = rx_word[7:0];
   assign rx_b1 = rx_word[15:8];
endmodule

/* dv/testbench.sv */
// Purpose: self-checking bench for the status word assembler
// Assumes: register reads answer one cycle after the strobe
// Notes: each scenario is a task that drives and judges
module testbench
   import smsa_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, ce, irq, prof_ok, exp_ok;
   logic [1:0] pb;
   logic [9:0] pc, pp;
   logic [7:0] b0, b1;
   logic [31:0] rdata, rd_v;
   smsa_src_t src;
   smsa_req_t req;
   smsa_word_t word;
   int n_mismatch, tests_run;

   // ==========================================================
   // design and far end
   smsa_assembler uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .SRC(src), .BUS_REQ(req),
      .BUS_RDATA(rdata), .TX_WORD(word), .TX_PROFILE_OK(prof_ok), .IRQ(irq));
   smsa_ctrl_model ctrl (.bus(pb), .con(pc), .pro(pp), .rx_word(word), .pair_ok(exp_ok),
      .rx_b0(b0), .rx_b1(b1));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================================
   // shared tasks
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      req <= '{1'b0, 1'b1, a, 32'h0};
      @(posedge clk);
      req <= '0;
      #1 rd_v = rdata;
   endtask

   task automatic put(input logic [65:0] v);
      @(posedge clk);
      src <= smsa_src_t'(v);
      tick(2);
   endtask

   task automatic close_out;
      $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      rd(ADR_CFG);
      chk("config after reset", rd_v, CFG_RST);
      chk("profile after reset", {31'h0, prof_ok}, 32'h1);
      chk("word after reset", {16'h0, word}, 32'h0);
      rd(8'h14);
      chk("unmapped read", rd_v, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_map;
      int bp[12] = '{34+ST_ESTOP, 34+ST_STANDSTILL, 18+POS_REF, 2+FN_A, 2+FN_B, 2+FN_C,
         2+FN_D, 34+ST_PARK, 1, 34+ST_FAULT, 18+POS_ENC, 0};
      logic [15:0] ew[12] = '{16'h0001, 16'h0002, 16'h0020, 16'h0040, 16'h0080, 16'h0100,
         16'h0200, 16'h0400, 16'h1000, 16'h2000, 16'h4000, 16'h8000};
      for (int k = 0; k < 12; k++)
      begin
         put(66'h1 << bp[k]);
         chk("status bit", {16'h0, b1, b0}, {16'h0, ew[k]});
      end
      put({66{1'b1}});
      chk("all sources set", {16'h0, b1, b0}, 32'h0000F7E3);
      $display("mapping test done");
   endtask

   task automatic t_mode;
      for (int i = 0; i < MODE_N; i++)
      begin
         put(66'h1 << (34 + ST_MODE_LO + i));
         chk("mode code", {27'h0, word[4:0]}, 32'(i << 2));
         rd(ADR_STAT);
         chk("mode flags", {30'h0, rd_v[18:17]}, 32'h0);
      end
      put((66'h1 << (35 + ST_MODE_LO)) | (66'h1 << (37 + ST_MODE_LO)));
      chk("two modes code", {27'h0, word[4:0]}, 32'h4);
      rd(ADR_STAT);
      chk("conflict flag", {30'h0, rd_v[18:17]}, 32'h1);
      put(66'h0);
      rd(ADR_STAT);
      chk("no mode flag", {30'h0, rd_v[18:17]}, 32'h2);
      $display("mode test done");
   endtask

   task automatic t_prof;
      logic [9:0] cs[6] = '{CON_778, CON_779, CON_780, CON_781, CON_786, CON_787};
      logic [9:0] ps[7] = '{PRO_782, PRO_783, PRO_784, PRO_785, PRO_788, PRO_789, PRO_790};
      for (int b = 0; b < 4; b++)
         for (int c = 0; c < 6; c++)
            for (int p = 0; p < 7; p++)
            begin
               pb = b[1:0];
               pc = cs[c];
               pp = ps[p];
               wr(ADR_CFG, {2'h0, pb, 2'h0, pp, 6'h00, pc});
               tick(2);
               chk("profile verdict", {31'h0, prof_ok}, {31'h0, exp_ok});
            end
      wr(ADR_CFG, {2'h0, BUS_CSOS, 2'h0, PRO_790, 6'h00, PRO_782});
      tick(2);
      chk("unknown consumer", {31'h0, prof_ok}, 32'h0);
      $display("profile test done");
   endtask

   task automatic t_irq;
      wr(ADR_IRQ_EN, 32'h1);
      put(66'h0);
      rd(ADR_IRQ_STAT);
      chk("pending events", rd_v, 32'h5);
      rd(ADR_IRQ_EN);
      chk("enable readback", rd_v, 32'h1);
      wr(ADR_IRQ_CLR, 32'h7);
      tick(1);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      put(66'h1 << (34 + ST_ESTOP));
      tick(1);
      chk("irq raised", {31'h0, irq}, 32'h1);
      rd(ADR_IRQ_STAT);
      chk("irq status", {31'h0, rd_v[IRQ_CHG]}, 32'h1);
      wr(ADR_IRQ_CLR, 32'h1);
      tick(1);
      chk("irq after clear", {31'h0, irq}, 32'h0);
      wr(ADR_IRQ_EN, 32'h0);
      put(66'h0);
      tick(1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd(ADR_IRQ_STAT);
      chk("masked status", {31'h0, rd_v[IRQ_CHG]}, 32'h1);
      wr(ADR_IRQ_CLR, 32'h7);
      wr(ADR_CFG, {2'h0, BUS_FSOE, 2'h0, PRO_782, 6'h00, CON_778});
      tick(2);
      rd(ADR_IRQ_STAT);
      chk("profile lost event", rd_v, 32'h2);
      wr(ADR_CFG, CFG_RST);
      wr(ADR_IRQ_CLR, 32'h7);
      wr(ADR_IRQ_EN, 32'h1);
      // word change and clear land on the same edge
      @(posedge clk);
      src <= smsa_src_t'(66'h1 << (34 + ST_STANDSTILL));
      req <= '{1'b1, 1'b0, ADR_IRQ_CLR, 32'h1};
      @(posedge clk);
      req <= '0;
      tick(1);
      chk("set beats clear", {31'h0, irq}, 32'h1);
      $display("interrupt test done");
   endtask

   task automatic t_hold;
      put(66'h0);
      @(posedge clk);
      ce <= 1'b0;
      src <= smsa_src_t'(66'h1 << (34 + ST_ESTOP));
      req <= '{1'b1, 1'b0, ADR_IRQ_EN, 32'h7};
      @(posedge clk);
      req <= '0;
      tick(2);
      chk("word frozen", {16'h0, word}, 32'h0);
      @(posedge clk);
      ce <= 1'b1;
      tick(2);
      chk("word after enable", {16'h0, word}, 32'h1);
      rd(ADR_IRQ_EN);
      chk("write dropped", rd_v, 32'h1);
      $display("enable test done");
   endtask

   // ==========================================================
   // main sequence and watchdog
   initial
   begin
      n_mismatch = 0;
      tests_run = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      src = '0;
      req = '0;
      pb = 2'h0;
      pc = CON_787;
      pp = PRO_790;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_map();
      t_mode();
      t_irq();
      t_hold();
      t_prof();
      close_out();
   end

   initial
   begin
      #2000000;
      n_mismatch++;
      $display("watchdog expired");
      close_out();
   end
endmodule
